// ### core/nsf_pkg.sv
package nsf_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] NSF_ADDR_STATUS = 4'h0;
    localparam logic [3:0] NSF_ADDR_IMASK = 4'h1;
    localparam logic [3:0] NSF_ADDR_BUSCTL = 4'h2;
    localparam logic [3:0] NSF_ADDR_EVENT = 4'h3;

    // ------------------------------------------------------------
    // Status and bus control bit positions
    // ------------------------------------------------------------
    localparam int NSF_BIT_RX_INHIB = 7;
    localparam int NSF_BIT_POR = 4;
    localparam int NSF_BIT_TEST = 3;
    localparam int NSF_BIT_RECON = 2;
    localparam int NSF_BIT_TMA = 1;
    localparam int NSF_BIT_TA = 0;
    localparam int NSF_BIT_WIDE = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] NSF_STATUS_RST = 8'h91;
    localparam logic [7:0] NSF_IMASK_RST = 8'h00;
    localparam logic [7:0] NSF_EVENT_RST = 8'h00;
    localparam logic NSF_WIDE_RST = 1'b0;
    // Status bits whose level may raise the interrupt through the mask
    localparam logic [7:0] NSF_INT_BITS = 8'h85;
    // Bits of the event register that exist
    localparam logic [7:0] NSF_EVENT_BITS = 8'h97;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam real NSF_CLK_MHZ = 125.0;
    localparam real NSF_IDLE_US = 20.5;
    localparam int NSF_IDLE_CYC_I = int'($ceil(NSF_IDLE_US * NSF_CLK_MHZ));
    localparam int NSF_IDLE_W = 12;
    localparam logic [NSF_IDLE_W-1:0] NSF_IDLE_CYC = NSF_IDLE_W'(NSF_IDLE_CYC_I);

    // ------------------------------------------------------------
    // Transmit tracking states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        NSF_TX_IDLE = 3'b001,
        NSF_TX_WAIT_TOKEN = 3'b010,
        NSF_TX_SENDING = 3'b100
    } nsf_tx_state_t;

endpackage : nsf_pkg

// ### core/nsf_node_status_flags.sv
// What this block does
// - Receiver inhibited after reset or packet stored, until enabled
// - Receive-enable command clears receiver inhibited
// - NAK senders while receiver inhibited
// - Interrupt on masked inhibit, reconfig, available
// - Reset or zero node id sets POR
// - Clear-flags command clears POR
// - Test bit reads zero
// - Line idle timeout sets reconfiguration flag
// - Clear-flags command clears reconfiguration flag
// - Acknowledged transmit sets TMA; valid after TA
// - Broadcast never sets TMA
// - Transmit-enable command clears TMA
// - Last byte or disable sets TA
// - TA clears at next token after enable
// - Wide bus select enables 16-bit access
// - Reset loads status pattern 1001 0001
//
// The register addresses and strobed register access were decided locally.
module nsf_node_status_flags
    import nsf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Host commands, one-cycle pulses
    input wire logic sw_reset,
    input wire logic receive_enable_command,
    input wire logic cmd_tx_enable,
    input wire logic cmd_tx_disable,
    input wire logic cmd_clear_flags,
    input wire logic node_id_zero_written,
    // Network events, one-cycle pulses except the offer, broadcast and line inputs
    input wire logic rx_packet_stored,
    input wire logic rx_packet_offered,
    input wire logic tx_ack_received,
    input wire logic tx_is_broadcast,
    input wire logic tx_last_byte_sent,
    input wire logic token_received,
    input wire logic line_receive_input,
    // Outputs
    output logic rx_accept_enable,
    output logic rx_nak_reply,
    output logic wide_bus_select,
    output logic irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic rx_inhibited_flag;
    logic por_flag;
    logic recon_flag;
    logic tma_flag;
    logic ta_flag;
    logic [7:0] interrupt_mask_reg;
    logic [7:0] event_reg;
    logic [7:0] status_view;
    logic [7:0] status_prev;
    logic [7:0] next_rdata;
    logic [NSF_IDLE_W-1:0] idle_cnt;
    logic idle_timeout;
    nsf_tx_state_t tx_state;
    nsf_tx_state_t next_tx_state;
    logic wr_imask;
    logic wr_busctl;
    logic rd_event;

    assign wr_imask = reg_wr && (reg_addr == NSF_ADDR_IMASK);
    assign wr_busctl = reg_wr && (reg_addr == NSF_ADDR_BUSCTL);
    assign rd_event = reg_rd && (reg_addr == NSF_ADDR_EVENT);

    // ------------------------------------------------------------
    // Status view
    // ------------------------------------------------------------
    always_comb
    begin
        status_view = 8'h00;
        status_view[NSF_BIT_RX_INHIB] = rx_inhibited_flag;
        status_view[NSF_BIT_POR] = por_flag;
        status_view[NSF_BIT_TEST] = 1'b0;
        status_view[NSF_BIT_RECON] = recon_flag;
        status_view[NSF_BIT_TMA] = tma_flag;
        status_view[NSF_BIT_TA] = ta_flag;
    end

    // ------------------------------------------------------------
    // Receiver inhibit
    // ------------------------------------------------------------
    // A stored packet in the same cycle as a new enable wins while the receiver is open, so the
    // host never misses that its page was consumed.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_inhibited_flag <= NSF_STATUS_RST[NSF_BIT_RX_INHIB];
        end
        else if (sw_reset)
        begin
            rx_inhibited_flag <= NSF_STATUS_RST[NSF_BIT_RX_INHIB];
        end
        else if (rx_packet_stored && !rx_inhibited_flag)
        begin
            rx_inhibited_flag <= 1'b1;
        end
        else if (receive_enable_command)
        begin
            rx_inhibited_flag <= 1'b0;
        end
    end

    assign rx_accept_enable = !rx_inhibited_flag;
    assign rx_nak_reply = rx_packet_offered && rx_inhibited_flag;

    // ------------------------------------------------------------
    // Power-on-reset flag
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            por_flag <= NSF_STATUS_RST[NSF_BIT_POR];
        end
        else if (sw_reset || node_id_zero_written)
        begin
            por_flag <= 1'b1;
        end
        else if (cmd_clear_flags)
        begin
            por_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Line idle timer
    // ------------------------------------------------------------
    // Any high level on the line counts as activity and restarts the
    // interval; the timer rearms itself after each expiry.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            idle_cnt <= '0;
        end
        else if (sw_reset || line_receive_input || idle_timeout)
        begin
            idle_cnt <= '0;
        end
        else
        begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end

    assign idle_timeout = (idle_cnt == NSF_IDLE_CYC - 1'b1) && !line_receive_input;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            recon_flag <= NSF_STATUS_RST[NSF_BIT_RECON];
        end
        else if (sw_reset)
        begin
            recon_flag <= NSF_STATUS_RST[NSF_BIT_RECON];
        end
        else if (idle_timeout)
        begin
            recon_flag <= 1'b1;
        end
        else if (cmd_clear_flags)
        begin
            recon_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Transmit tracking
    // ------------------------------------------------------------
    always_comb
    begin
        next_tx_state = tx_state;
        case (tx_state)
            NSF_TX_IDLE:
            begin
                if (cmd_tx_enable)
                begin
                    next_tx_state = NSF_TX_WAIT_TOKEN;
                end
            end
            NSF_TX_WAIT_TOKEN:
            begin
                if (cmd_tx_disable)
                begin
                    next_tx_state = NSF_TX_IDLE;
                end
                else if (token_received)
                begin
                    next_tx_state = NSF_TX_SENDING;
                end
            end
            NSF_TX_SENDING:
            begin
                if (cmd_tx_disable || tx_last_byte_sent)
                begin
                    next_tx_state = NSF_TX_IDLE;
                end
            end
            default:
            begin
                next_tx_state = NSF_TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_state <= NSF_TX_IDLE;
        end
        else if (sw_reset)
        begin
            tx_state <= NSF_TX_IDLE;
        end
        else
        begin
            tx_state <= next_tx_state;
        end
    end

    // Available drops only when the token arrives, not at the command
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ta_flag <= NSF_STATUS_RST[NSF_BIT_TA];
        end
        else if (sw_reset)
        begin
            ta_flag <= NSF_STATUS_RST[NSF_BIT_TA];
        end
        else if (cmd_tx_disable)
        begin
            ta_flag <= 1'b1;
        end
        else if (tx_state == NSF_TX_SENDING && tx_last_byte_sent)
        begin
            ta_flag <= 1'b1;
        end
        else if (tx_state == NSF_TX_WAIT_TOKEN && token_received)
        begin
            ta_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            tma_flag <= NSF_STATUS_RST[NSF_BIT_TMA];
        end
        else if (sw_reset)
        begin
            tma_flag <= NSF_STATUS_RST[NSF_BIT_TMA];
        end
        else if (tx_ack_received && !tx_is_broadcast && tx_state != NSF_TX_IDLE)
        begin
            tma_flag <= 1'b1;
        end
        else if (cmd_tx_enable)
        begin
            tma_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Mask, bus control and event registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            interrupt_mask_reg <= NSF_IMASK_RST;
        end
        else if (wr_imask)
        begin
            interrupt_mask_reg <= reg_wdata;
        end
    end

    // Bus width is a host interface setting, kept through soft reset
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            wide_bus_select <= NSF_WIDE_RST;
        end
        else if (wr_busctl)
        begin
            wide_bus_select <= reg_wdata[NSF_BIT_WIDE];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            status_prev <= NSF_STATUS_RST;
        end
        else
        begin
            status_prev <= status_view;
        end
    end

    // Rising flags latch here; a read clears, a new rise in that cycle wins
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            event_reg <= NSF_EVENT_RST;
        end
        else if (rd_event)
        begin
            event_reg <= status_view & ~status_prev & NSF_EVENT_BITS;
        end
        else
        begin
            event_reg <= event_reg | (status_view & ~status_prev & NSF_EVENT_BITS);
        end
    end

    // ------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------
    always_comb
    begin
        irq = |(status_view & interrupt_mask_reg & NSF_INT_BITS);
        irq = irq || |(event_reg & interrupt_mask_reg);
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Status writes fall through the decoder untouched.
    always_comb
    begin
        next_rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                NSF_ADDR_STATUS: next_rdata = status_view;
                NSF_ADDR_IMASK: next_rdata = interrupt_mask_reg;
                NSF_ADDR_BUSCTL: next_rdata = {7'h00, wide_bus_select};
                NSF_ADDR_EVENT: next_rdata = event_reg;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            reg_rdata <= next_rdata;
        end
    end

endmodule : nsf_node_status_flags

// ### tb/nsf_node_status_flags_checker.sv
// ----------------------------------------
// Port-level checks
// ----------------------------------------
module nsf_node_status_flags_checker
    import nsf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic sw_reset,
    input wire logic receive_enable_command,
    input wire logic rx_packet_stored,
    input wire logic rx_packet_offered,
    input wire logic rx_accept_enable,
    input wire logic rx_nak_reply,
    input wire logic wide_bus_select
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    property p_nak;
        rx_nak_reply == (rx_packet_offered && !rx_accept_enable);
    endproperty
    a_nak: assert property (p_nak) else $error("nak reply wrong");
    property p_rx_open;
        receive_enable_command && !rx_packet_stored && !sw_reset |=> rx_accept_enable;
    endproperty
    a_rx_open: assert property (p_rx_open) else $error("receiver not opened");
    property p_rx_close;
        rx_accept_enable && rx_packet_stored |=> !rx_accept_enable;
    endproperty
    a_rx_close: assert property (p_rx_close) else $error("receiver not shut");
    property p_rx_hold;
        !rx_accept_enable && !receive_enable_command |=> !rx_accept_enable;
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("receiver opened alone");
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    // Inhibit bit must mirror the receive gate seen in the read cycle
    property p_status_bits;
        $past(reg_rd) && $past(reg_addr) == NSF_ADDR_STATUS
            |-> reg_rdata[7] == !$past(rx_accept_enable) && reg_rdata[3] == 1'b0;
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("status bits");
    property p_wide;
        reg_wr && reg_addr == NSF_ADDR_BUSCTL |=> wide_bus_select == $past(reg_wdata[0]);
    endproperty
    a_wide: assert property (p_wide) else $error("wide select not written");
    property p_rst;
        $rose(resetn) |-> !rx_accept_enable && !wide_bus_select;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : nsf_node_status_flags_checker

bind nsf_node_status_flags nsf_node_status_flags_checker u_chk (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sw_reset(sw_reset), .receive_enable_command(receive_enable_command),
    .rx_packet_stored(rx_packet_stored),
    .rx_packet_offered(rx_packet_offered), .rx_accept_enable(rx_accept_enable),
    .rx_nak_reply(rx_nak_reply), .wide_bus_select(wide_bus_select)
);

// ### tb/nsf_host_model.sv
// ----------------------------------------
// Host side of the register port
// ----------------------------------------
module nsf_host_model
    import nsf_pkg::*;
(
    input wire logic clk_sys,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Idle lines flip so a stale address never repeats the last one
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
    endtask : rd
endmodule : nsf_host_model

// ### tb/nsf_node_status_flags_bench.sv
module nsf_node_status_flags_bench
    import nsf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, resetn, offered, bcast, line, wr, rd, acc, nak, wide, irq;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, d;
    // 0 swrst 1 rxen 2 txen 3 txdis 4 clr 5 nid0 6 stored 7 ack 8 last 9 token
    logic [9:0] ev;
    int compares = 0;
    int miscompares = 0;

    nsf_host_model u_host (.clk_sys(clk_sys), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
    nsf_node_status_flags u_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .sw_reset(ev[0]), .receive_enable_command(ev[1]), .cmd_tx_enable(ev[2]),
        .cmd_tx_disable(ev[3]), .cmd_clear_flags(ev[4]), .node_id_zero_written(ev[5]),
        .rx_packet_stored(ev[6]), .rx_packet_offered(offered), .tx_ack_received(ev[7]),
        .tx_is_broadcast(bcast), .tx_last_byte_sent(ev[8]), .token_received(ev[9]),
        .line_receive_input(line), .rx_accept_enable(acc), .rx_nak_reply(nak),
        .wide_bus_select(wide), .irq(irq));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task st(input logic [7:0] exp);
        logic [7:0] s;
        u_host.rd(NSF_ADDR_STATUS, s);
        chk(s, exp);
    endtask : st
    task pulse(input int i);
        @(posedge clk_sys) ev[i] <= 1'b1;
        @(posedge clk_sys) ev[i] <= 1'b0;
    endtask : pulse
    task tick;
        @(posedge clk_sys);
        #1;
    endtask : tick
    task give_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        st(8'h91);
        u_host.rd(NSF_ADDR_IMASK, d);
        chk(d, 8'h00);
        u_host.rd(4'hf, d);
        chk(d, 8'h00);
        $display("reset test done");
    endtask : t_reset
    task t_rx;
        @(posedge clk_sys) offered <= 1'b1;
        tick();
        chk({7'h00, nak}, 8'h01);
        chk({7'h00, acc}, 8'h00);
        pulse(1);
        st(8'h11);
        chk({7'h00, nak}, 8'h00);
        chk({7'h00, acc}, 8'h01);
        pulse(6);
        st(8'h91);
        pulse(6);
        st(8'h91);
        @(posedge clk_sys) offered <= 1'b0;
        $display("receive test done");
    endtask : t_rx
    task t_por;
        pulse(4);
        st(8'h81);
        pulse(5);
        st(8'h91);
        pulse(4);
        st(8'h81);
        $display("reset flag test done");
    endtask : t_por
    task t_tx;
        pulse(2);
        repeat (3) tick();
        st(8'h81);
        pulse(9);
        st(8'h80);
        pulse(7);
        st(8'h82);
        pulse(8);
        st(8'h83);
        pulse(2);
        st(8'h81);
        pulse(9);
        @(posedge clk_sys) bcast <= 1'b1;
        pulse(7);
        st(8'h80);
        @(posedge clk_sys) bcast <= 1'b0;
        pulse(3);
        st(8'h81);
        $display("transmit test done");
    endtask : t_tx
    task t_recon;
        @(posedge clk_sys) line <= 1'b0;
        // Reads land on the last edge before and the first edge after expiry
        repeat (NSF_IDLE_CYC_I - 3) @(posedge clk_sys);
        st(8'h81);
        st(8'h85);
        @(posedge clk_sys) line <= 1'b1;
        pulse(4);
        st(8'h81);
        $display("reconfig test done");
    endtask : t_recon
    task t_irq;
        // Every flag has risen once since reset and none was read yet
        u_host.rd(NSF_ADDR_EVENT, d);
        chk(d, 8'h97);
        u_host.rd(NSF_ADDR_EVENT, d);
        chk(d, 8'h00);
        u_host.wr(NSF_ADDR_IMASK, 8'h01);
        tick();
        chk({7'h00, irq}, 8'h01);
        u_host.wr(NSF_ADDR_IMASK, 8'h04);
        tick();
        chk({7'h00, irq}, 8'h00);
        u_host.wr(NSF_ADDR_IMASK, 8'h80);
        tick();
        chk({7'h00, irq}, 8'h01);
        u_host.wr(NSF_ADDR_IMASK, 8'h00);
        tick();
        chk({7'h00, irq}, 8'h00);
        u_host.wr(NSF_ADDR_STATUS, 8'h00);
        st(8'h81);
        $display("interrupt test done");
    endtask : t_irq
    task t_wide;
        u_host.wr(NSF_ADDR_BUSCTL, 8'h01);
        u_host.rd(NSF_ADDR_BUSCTL, d);
        chk({6'h00, d[0], wide}, 8'h03);
        pulse(0);
        st(8'h91);
        chk({7'h00, wide}, 8'h01);
        @(posedge clk_sys) resetn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        st(8'h91);
        chk({7'h00, wide}, 8'h00);
        $display("bus select test done");
    endtask : t_wide

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Cuts a hang short
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        $display("CHECK FAILED at %0t: timeout", $time);
        give_verdict();
    end
    initial
    begin
        resetn = 1'b0;
        ev = '0;
        offered = 1'b0;
        bcast = 1'b0;
        line = 1'b1;
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        t_rx();
        t_por();
        t_tx();
        t_recon();
        t_irq();
        t_wide();
        give_verdict();
    end
endmodule : nsf_node_status_flags_bench
